// File: shared/ash_pkg.sv
// shared constants for the adapter serial host interface
package ash_pkg;
    // option register offsets
    localparam logic [15:0] ASH_OFF_BOARD_CTRL  = 16'h0102;
    localparam logic [15:0] ASH_OFF_ARB_CONFIG  = 16'h0104;
    localparam logic [15:0] ASH_OFF_CHK_STATUS  = 16'h0105;
    // field positions
    localparam int          ASH_BOARD_EN_BIT    = 0;
    localparam int          ASH_ARB_LEVEL_LSB   = 3;
    localparam int          ASH_ARB_LEVEL_W     = 4;
    localparam int          ASH_FAIR_BIT        = 7;
    localparam int          ASH_CHK_BIT         = 7;
    // reset values
    localparam logic [7:0]  ASH_ARB_RESET       = 8'h00;
    localparam logic [7:0]  ASH_BOARD_RESET     = 8'h00;
    // serial controller register counts
    localparam int          ASH_NUM_RD_REGS     = 9;
    localparam int          ASH_NUM_WR_REGS     = 15;
    localparam logic [3:0]  ASH_REG_IRQ_VECTOR  = 4'h2;
    localparam logic [3:0]  ASH_REG_CMD_ZERO    = 4'h0;
    localparam logic [7:0]  ASH_IRQ_RESET_CMD   = 8'h38;
    // select block geometry
    localparam int          ASH_BLOCK_BITS      = 2;
    localparam int          ASH_NUM_BLOCKS      = 8;
    localparam logic [15:0] ASH_SCC_BASE_DEF    = 16'h0300;
    localparam logic [15:0] ASH_BLOCK_STRIDE    = 16'h0010;
    // host command codes
    typedef enum logic [1:0] {
        ASH_CMD_OPT_RD = 2'h0,
        ASH_CMD_OPT_WR = 2'h1,
        ASH_CMD_SCC_RD = 2'h2,
        ASH_CMD_SCC_WR = 2'h3
    } ash_cmd_t;
endpackage : ash_pkg

// File: shared/ash_bus_if.sv
// expansion bus between host and adapter, open-collector lines resolved here
`timescale 1ns/1ns
interface ash_bus_if;
    logic [15:0] addr;
    logic        address_latch_strobe_n;
    logic        cmd_n;
    logic        write_n_status;
    logic [7:0]  host_data;
    logic [7:0]  dev_data;
    logic        dev_data_oe;
    logic        host_irq_line_three_oe;
    logic        bus_check_oe;
    logic        card_select_fb_n;
    wire         host_irq_line_three_n = ~host_irq_line_three_oe;
    wire         bus_check_line_n      = ~bus_check_oe;
    wire  [7:0]  data = dev_data_oe ? dev_data : host_data;

    modport dev (
        input  addr, address_latch_strobe_n, cmd_n, write_n_status, host_data,
        input  bus_check_line_n,
        output dev_data, dev_data_oe, host_irq_line_three_oe, bus_check_oe,
        output card_select_fb_n
    );
    modport host (
        output addr, address_latch_strobe_n, cmd_n, write_n_status, host_data,
        input  data, host_irq_line_three_n, bus_check_line_n, card_select_fb_n
    );
endinterface : ash_bus_if

// File: design/ash_scc_regs.sv
// serial controller register file reached through the pointer mechanism
`timescale 1ns/1ns
module ash_scc_regs
    import ash_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // access strobes
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    input  wire logic       data_sel,
    input  wire logic       chan_b,
    input  wire logic [7:0] wdata,
    // serial events
    input  wire logic       rx_byte_evt,
    input  wire logic       tx_empty_evt,
    input  wire logic       err_evt,
    // results
    output logic      [7:0] rdata,
    output logic            irq_req
);
    logic [3:0] ptr_reg;
    logic [7:0] wr_reg   [2][ASH_NUM_WR_REGS];
    logic [7:0] data_reg [2];
    logic [2:0] pend_reg;
    logic [3:0] ptr_next;
    wire        ch      = chan_b;
    wire        cmd_wr  = wr_stb && !data_sel;
    wire        at_ptr  = (ptr_reg == ASH_REG_CMD_ZERO);
    wire        irq_clr = cmd_wr && !at_ptr ? 1'b0 :
                          (cmd_wr && at_ptr && wdata == ASH_IRQ_RESET_CMD);
    wire [2:0]  evt     = {err_evt, tx_empty_evt, rx_byte_evt};
    wire [7:0]  ien     = wr_reg[0][1];

    // pointer returns to zero after the one access it steers
    always_comb begin
        ptr_next = ptr_reg;
        if ((wr_stb || rd_stb) && !data_sel) begin
            // a reset command written at the pointer leaves the pointer at zero
            ptr_next = (wr_stb && at_ptr && !irq_clr) ? wdata[3:0] : ASH_REG_CMD_ZERO;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ptr_reg  <= ASH_REG_CMD_ZERO;
            pend_reg <= '0;
            data_reg <= '{default: '0};
            wr_reg   <= '{default: '{default: '0}};
        end else begin
            ptr_reg  <= ptr_next;
            // a new event wins over a simultaneous reset command
            pend_reg <= (irq_clr ? 3'h0 : pend_reg) | evt;
            if (cmd_wr && !at_ptr && ptr_reg < 4'(ASH_NUM_WR_REGS))
                wr_reg[ch][ptr_reg] <= wdata;
            if (wr_stb && data_sel)
                data_reg[ch] <= wdata;
        end
    end

    always_comb begin
        rdata = 8'h00;
        if (data_sel) rdata = data_reg[ch];
        else if (ptr_reg == ASH_REG_IRQ_VECTOR) rdata = {5'h00, pend_reg};
        else if (ptr_reg < 4'(ASH_NUM_RD_REGS)) rdata = wr_reg[ch][ptr_reg];
    end

    assign irq_req = |(pend_reg & ien[2:0]);
endmodule : ash_scc_regs

// File: design/ash_adapter.sv
// adapter end: option registers, select decode, strobes, irq and check lines
`timescale 1ns/1ns
// Summary of operation
// - arbitration level and fairness bits, read-write
// - arbitration runs without local clocked logic
// - arbitration bits sit in 0104 bits 3-7
// - host writes pointer before command access
// - pointer returns after one access
// - nine readable, fifteen writable controller registers
// - low latched address bits pick channel, type
// - four-location blocks, eight bases, aligned
// - select latched by address strobe, held
// - strobes made from command strobe going active
// - driver picks interrupt or DMA mode
// - interrupts on receive, transmit empty, errors
// - interrupt drives shared active-low line three
// - host acknowledges with ordinary reads, writes
// - check line level, shared, open-collector
// - check pulse asserts line, clears 0105 bit7
// - host polls status bit on each adapter
// - board disabled suppresses selects and interrupts
module ash_adapter
    import ash_pkg::*;
#(
    parameter int ARB_W = ASH_ARB_LEVEL_W
)(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // expansion bus
    ash_bus_if.dev    bus,
    // adapter-side inputs
    input  wire logic raise_bus_check_n,
    input  wire logic rx_byte_evt,
    input  wire logic tx_empty_evt,
    input  wire logic err_evt,
    input  wire logic dma_mode,
    // adapter-side outputs
    output logic      board_enabled_n,
    output logic [ARB_W-1:0] arb_level,
    output logic      arb_fair_en,
    output logic      decoded_select_n,
    output logic      transceiver_enable_n,
    output logic      transceiver_direction,
    output logic      board_io_write_n
);
    // the field slicing below is fixed at the four-bit level
    if (ARB_W != ASH_ARB_LEVEL_W) begin : g_arb_w_check
        $error("arbitration level width must be four");
    end

    logic [7:0]  board_reg, arb_reg, sel_reg;
    logic        chk_ok_reg, chk_drive_reg, sel_latched_reg, opt_latched_reg;
    logic [1:0]  low_addr_reg;
    logic        cmd_d_reg, wr_pulse_reg, board_off_reg;
    logic        ce_out_reg, irq_oe_reg, fb_reg;
    logic [7:0]  rdata_reg;
    logic        oe_reg;
    logic [7:0]  scc_rdata;
    logic        scc_irq;

    // blocks sit a fixed stride apart, so any index lands on a four-byte boundary
    function automatic logic [15:0] block_base(input logic [2:0] idx);
        return ASH_SCC_BASE_DEF + 16'(idx) * ASH_BLOCK_STRIDE;
    endfunction : block_base

    // address decode
    wire        enabled   = board_reg[ASH_BOARD_EN_BIT];
    wire [15:0] blk_addr  = {bus.addr[15:ASH_BLOCK_BITS], {ASH_BLOCK_BITS{1'b0}}};
    wire        scc_hit   = enabled && (blk_addr == block_base(sel_reg[2:0]));
    wire        opt_hit   = (bus.addr >= ASH_OFF_BOARD_CTRL) && (bus.addr <= ASH_OFF_CHK_STATUS);
    wire        adl_act   = !bus.address_latch_strobe_n;
    wire        cmd_fall  = !bus.cmd_n && cmd_d_reg;
    wire        is_wr     = !bus.write_n_status;
    wire        scc_wr    = cmd_fall && is_wr && sel_latched_reg;
    wire        scc_rd    = cmd_fall && !is_wr && sel_latched_reg;
    wire        opt_wr    = cmd_fall && is_wr && opt_latched_reg;
    wire        opt_rd    = cmd_fall && !is_wr && opt_latched_reg;
    wire [15:0] opt_addr  = bus.addr;
    // option register decode, shared by the write and read paths
    wire        opt_is_board = (opt_addr == ASH_OFF_BOARD_CTRL);
    wire        opt_is_sel   = (opt_addr == ASH_OFF_BOARD_CTRL + 16'h0001);
    wire        opt_is_arb   = (opt_addr == ASH_OFF_ARB_CONFIG);
    wire        opt_is_chk   = (opt_addr == ASH_OFF_CHK_STATUS);
    // unmapped offsets inside the window read back in the status format
    wire [7:0]  opt_rdata    = opt_is_board ? board_reg :
                               opt_is_sel   ? sel_reg   :
                               opt_is_arb   ? arb_reg   : {chk_ok_reg, 7'h00};
    // command levels qualified by a latched select
    wire        bus_rd       = !bus.cmd_n && !is_wr && (sel_latched_reg || opt_latched_reg);
    wire        bus_wr       = !bus.cmd_n && is_wr && (sel_latched_reg || opt_latched_reg);
    wire        chk_pulse = !raise_bus_check_n;
    wire        irq_ok    = enabled && scc_irq && !dma_mode;

    // channel and access type follow the latched low address bits
    ash_scc_regs u_scc (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .wr_stb       (scc_wr),
        .rd_stb       (scc_rd),
        .data_sel     (low_addr_reg[0]),
        .chan_b       (low_addr_reg[1]),
        .wdata        (bus.host_data),
        .rx_byte_evt  (rx_byte_evt),
        .tx_empty_evt (tx_empty_evt),
        .err_evt      (err_evt),
        .rdata        (scc_rdata),
        .irq_req      (scc_irq)
    );

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_latched_reg <= 1'b0;
            opt_latched_reg <= 1'b0;
            low_addr_reg    <= 2'h0;
            ce_out_reg      <= 1'b1;
        end else if (adl_act) begin
            // selects are frozen for the rest of the cycle once the strobe goes
            sel_latched_reg <= scc_hit;
            opt_latched_reg <= opt_hit;
            low_addr_reg    <= bus.addr[1:0];
            // the pin moves with the latch, on the same edge that the command strobe goes active
            ce_out_reg      <= !scc_hit;
        end
    end

    // host-visible option registers; the board bit also gates selects and irq
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            board_reg     <= ASH_BOARD_RESET;
            board_off_reg <= !ASH_BOARD_RESET[ASH_BOARD_EN_BIT];
            arb_reg       <= ASH_ARB_RESET;
            sel_reg       <= 8'h00;
        end else if (opt_wr) begin
            if (opt_is_board) board_reg <= bus.host_data;
            if (opt_is_board) board_off_reg <= !bus.host_data[ASH_BOARD_EN_BIT];
            if (opt_is_sel) sel_reg <= bus.host_data;
            if (opt_is_arb) arb_reg <= bus.host_data;
        end
    end

    // check bit: the pulse wins over a host write that tries to set it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chk_ok_reg    <= 1'b1;
            chk_drive_reg <= 1'b0;
        end else if (chk_pulse) begin
            chk_ok_reg    <= 1'b0;
            chk_drive_reg <= 1'b1;
        end else if (opt_wr && opt_is_chk) begin
            chk_ok_reg    <= bus.host_data[ASH_CHK_BIT];
            chk_drive_reg <= !bus.host_data[ASH_CHK_BIT];
        end
    end

    // write strobe and transceiver direction follow the command strobe level; the transceiver enable follows the latched selects
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cmd_d_reg    <= 1'b1;
            wr_pulse_reg <= 1'b1;
            fb_reg       <= 1'b1;
        end else begin
            cmd_d_reg    <= bus.cmd_n;
            wr_pulse_reg <= !bus_wr;
            fb_reg       <= !(sel_latched_reg || opt_latched_reg);
        end
    end

    // dma mode and a disabled board keep the shared line released
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_oe_reg <= 1'b0;
        end else begin
            irq_oe_reg <= irq_ok;
        end
    end

    // read data is driven one cycle behind the read command strobe level, for as long as it is held
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
            oe_reg    <= 1'b0;
        end else begin
            oe_reg    <= bus_rd;
            // captured at the strobe edge and held while the drive is up
            if (scc_rd) rdata_reg <= scc_rdata;
            else if (opt_rd) rdata_reg <= opt_rdata;
        end
    end

    // every output below is a flop or a slice of one
    // arbitration state machine is asynchronous and lives outside; only its bits are here
    assign arb_level              = arb_reg[ASH_ARB_LEVEL_LSB +: ASH_ARB_LEVEL_W];
    assign arb_fair_en            = arb_reg[ASH_FAIR_BIT];
    assign board_enabled_n        = board_off_reg;
    assign decoded_select_n       = ce_out_reg;
    assign transceiver_enable_n   = fb_reg;
    assign transceiver_direction  = wr_pulse_reg;
    assign board_io_write_n       = wr_pulse_reg;
    assign bus.dev_data           = rdata_reg;
    assign bus.dev_data_oe        = oe_reg;
    // open-collector lines: the enables only pull, the interface resolves the level
    assign bus.host_irq_line_three_oe = irq_oe_reg;
    assign bus.bus_check_oe       = chk_drive_reg;
    assign bus.card_select_fb_n   = fb_reg;
endmodule : ash_adapter

// File: design/ash_host.sv
// host end: runs bus cycles, pointer-then-register access for the controller
`timescale 1ns/1ns
module ash_host
    import ash_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // expansion bus
    ash_bus_if.host          bus,
    // user request
    input  wire logic        req_valid,
    input  wire ash_cmd_t    req_cmd,
    input  wire logic [15:0] req_addr,
    input  wire logic [3:0]  req_reg,
    input  wire logic [7:0]  req_wdata,
    // user answer
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             irq_seen,
    output logic             check_seen
);
    typedef enum logic [3:0] {
        ASH_IDLE = 4'b0001,
        ASH_ADL  = 4'b0010,
        ASH_CMD  = 4'b0100,
        ASH_END  = 4'b1000
    } ash_hstate_t;

    ash_hstate_t state_reg, state_next;
    logic        ptr_phase_reg;
    ash_cmd_t    cmd_reg;
    logic [15:0] addr_reg;
    logic [3:0]  reg_reg;
    logic [7:0]  wdata_reg, rdata_reg;
    logic        rsp_reg, irq_reg, chk_reg;

    wire is_write  = ptr_phase_reg || cmd_reg == ASH_CMD_OPT_WR || cmd_reg == ASH_CMD_SCC_WR;
    wire last_cyc  = !(ptr_phase_reg);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ASH_IDLE: if (req_valid) state_next = ASH_ADL;
            ASH_ADL:  state_next = ASH_CMD;
            ASH_CMD:  state_next = ASH_END;
            ASH_END:  state_next = last_cyc ? ASH_IDLE : ASH_ADL;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg     <= ASH_IDLE;
            ptr_phase_reg <= 1'b0;
            cmd_reg       <= ASH_CMD_OPT_RD;
            addr_reg      <= 16'h0000;
            reg_reg       <= 4'h0;
            wdata_reg     <= 8'h00;
            rdata_reg     <= 8'h00;
            rsp_reg       <= 1'b0;
            irq_reg       <= 1'b0;
            chk_reg       <= 1'b0;
        end else begin
            state_reg <= state_next;
            rsp_reg   <= 1'b0;
            irq_reg   <= !bus.host_irq_line_three_n;
            chk_reg   <= !bus.bus_check_line_n;
            if (state_reg == ASH_IDLE && req_valid) begin
                cmd_reg       <= req_cmd;
                addr_reg      <= req_addr;
                reg_reg       <= req_reg;
                wdata_reg     <= req_wdata;
                // command register access opens with a pointer write
                ptr_phase_reg <= (req_cmd == ASH_CMD_SCC_RD || req_cmd == ASH_CMD_SCC_WR)
                                 && !req_addr[0];
            end
            // the adapter drives read data in the cycle after the command strobe
            if (state_reg == ASH_END && !is_write) rdata_reg <= bus.data;
            if (state_reg == ASH_END) begin
                if (ptr_phase_reg) ptr_phase_reg <= 1'b0;
                else rsp_reg <= 1'b1;
            end
        end
    end

    assign bus.addr                   = addr_reg;
    assign bus.address_latch_strobe_n = !(state_reg == ASH_ADL);
    assign bus.cmd_n                  = !(state_reg == ASH_CMD);
    assign bus.write_n_status         = !is_write;
    assign bus.host_data              = ptr_phase_reg ? {4'h0, reg_reg} : wdata_reg;
    assign req_ready                  = (state_reg == ASH_IDLE);
    assign rsp_valid                  = rsp_reg;
    assign rsp_rdata                  = rdata_reg;
    assign irq_seen                   = irq_reg;
    assign check_seen                 = chk_reg;
endmodule : ash_host

// File: test/ash_bus_chk.sv
// concurrent checks on the bus between host end and adapter end
`timescale 1ns/1ns
module ash_bus_chk (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // bus lines
    input wire logic       cmd_n,
    input wire logic       write_n_status,
    input wire logic       dev_data_oe,
    input wire logic       host_irq_line_three_oe,
    input wire logic       bus_check_oe,
    // adapter side
    input wire logic       raise_bus_check_n,
    input wire logic       board_enabled_n,
    input wire logic       decoded_select_n,
    input wire logic       board_io_write_n,
    input wire logic [3:0] arb_level,
    input wire logic       arb_fair_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_off_quiet;
        board_enabled_n && $past(board_enabled_n) |-> decoded_select_n && !host_irq_line_three_oe;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("select or irq while board disabled");
    property p_sel_held;
        !cmd_n |=> $stable(decoded_select_n);
    endproperty
    a_sel_held: assert property (p_sel_held)
        else $error("select moved during command");
    property p_wr_from_cmd;
        $fell(board_io_write_n) |-> !($past(cmd_n) && cmd_n);
    endproperty
    a_wr_from_cmd: assert property (p_wr_from_cmd)
        else $error("write strobe without command");
    property p_rd_from_cmd;
        $rose(dev_data_oe) |-> !($past(cmd_n) && cmd_n) && write_n_status;
    endproperty
    a_rd_from_cmd: assert property (p_rd_from_cmd)
        else $error("read drive without read command");
    property p_irq_enabled;
        $rose(host_irq_line_three_oe) |-> !board_enabled_n;
    endproperty
    a_irq_enabled: assert property (p_irq_enabled)
        else $error("irq line pulled while board disabled");
    property p_check_raise;
        $fell(raise_bus_check_n) |-> ##[0:3] bus_check_oe;
    endproperty
    a_check_raise: assert property (p_check_raise)
        else $error("check line not pulled after raise");
    property p_check_level;
        $rose(bus_check_oe) |=> bus_check_oe[*4];
    endproperty
    a_check_level: assert property (p_check_level)
        else $error("check line dropped early");
    property p_arb_quiet;
        cmd_n && $past(cmd_n) && $past(cmd_n, 2) |-> $stable(arb_level) && $stable(arb_fair_en);
    endproperty
    a_arb_quiet: assert property (p_arb_quiet)
        else $error("arbitration bits moved outside a command");
endmodule : ash_bus_chk

// File: test/tb_adapter_serial_host_interface.sv
// self-checking bench: host end and adapter end joined through the bus interface
`timescale 1ns/1ns
module tb_adapter_serial_host_interface
    import ash_pkg::*;
;
    logic        ref_clk, nrst, req_valid, req_ready, rsp_valid, irq_seen, check_seen;
    ash_cmd_t    req_cmd;
    logic [15:0] req_addr;
    logic [3:0]  req_reg, arb_level;
    logic [7:0]  req_wdata, rsp_rdata, rd;
    logic [2:0]  evt;
    logic        raise_bus_check_n, dma_mode, board_enabled_n, arb_fair_en;
    logic        decoded_select_n, board_io_write_n, sel_hit;
    int          error_cnt = 0;
    int          n_checks = 0;

    ash_bus_if i_ash_bus_if ();
    ash_adapter i_ash_adapter (.ref_clk(ref_clk), .nrst(nrst), .bus(i_ash_bus_if),
        .raise_bus_check_n(raise_bus_check_n), .rx_byte_evt(evt[0]), .tx_empty_evt(evt[1]),
        .err_evt(evt[2]), .dma_mode(dma_mode), .board_enabled_n(board_enabled_n),
        .arb_level(arb_level), .arb_fair_en(arb_fair_en), .decoded_select_n(decoded_select_n),
        .transceiver_enable_n(), .transceiver_direction(), .board_io_write_n(board_io_write_n));
    ash_host i_ash_host (.ref_clk(ref_clk), .nrst(nrst), .bus(i_ash_bus_if),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_reg(req_reg),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .irq_seen(irq_seen), .check_seen(check_seen));
    ash_bus_chk i_ash_bus_chk (.ref_clk(ref_clk), .nrst(nrst), .cmd_n(i_ash_bus_if.cmd_n),
        .write_n_status(i_ash_bus_if.write_n_status), .dev_data_oe(i_ash_bus_if.dev_data_oe),
        .host_irq_line_three_oe(i_ash_bus_if.host_irq_line_three_oe),
        .bus_check_oe(i_ash_bus_if.bus_check_oe), .raise_bus_check_n(raise_bus_check_n),
        .board_enabled_n(board_enabled_n), .decoded_select_n(decoded_select_n),
        .board_io_write_n(board_io_write_n), .arb_level(arb_level), .arb_fair_en(arb_fair_en));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (decoded_select_n === 1'b0 && i_ash_bus_if.cmd_n === 1'b0) sel_hit <= 1'b1;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    // one user request; cycles are numbered from the one after the taking edge
    task automatic do_req(input ash_cmd_t c, input logic [15:0] a, input logic [3:0] r,
                          input logic [7:0] w, input int lat);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        req_cmd = c;
        req_addr = a;
        req_reg = r;
        req_wdata = w;
        req_valid = 1'b1;
        cyc(1);
        req_valid = 1'b0;
        n = 1;
        while (rsp_valid !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        chk("answer delay", lat[15:0], n[15:0]);
        rd = rsp_rdata;
    endtask : do_req

    task automatic sel(input logic [15:0] a, input int lat, input logic exp_n);
        sel_hit = 1'b0;
        do_req(ASH_CMD_SCC_RD, a, 4'h0, 8'h00, lat);
        chk("select", exp_n, !sel_hit);
    endtask : sel

    // bounded wait: a masked event leaves the line high for the whole span
    task automatic pulse(input int i);
        int n;
        evt[i] = 1'b1;
        cyc(1);
        evt[i] = 1'b0;
        n = 0;
        while (i_ash_bus_if.host_irq_line_three_n !== 1'b0 && n < 8) begin
            cyc(1);
            n++;
        end
    endtask : pulse

    task automatic t_reset();
        do_req(ASH_CMD_OPT_RD, ASH_OFF_ARB_CONFIG, 4'h0, 8'h00, 4);
        chk("arb reset", ASH_ARB_RESET, rd);
        do_req(ASH_CMD_OPT_RD, ASH_OFF_CHK_STATUS, 4'h0, 8'h00, 4);
        chk("check bit idle", 1'b1, rd[ASH_CHK_BIT]);
        chk("board off", 1'b1, board_enabled_n);
        $display("test reset done");
    endtask : t_reset

    task automatic t_arb();
        logic [7:0] v [2] = '{8'hb8, 8'h40};
        foreach (v[i]) begin
            do_req(ASH_CMD_OPT_WR, ASH_OFF_ARB_CONFIG, 4'h0, v[i], 4);
            chk("arb level", v[i][ASH_ARB_LEVEL_LSB +: ASH_ARB_LEVEL_W], arb_level);
            chk("fairness", v[i][ASH_FAIR_BIT], arb_fair_en);
            do_req(ASH_CMD_OPT_RD, ASH_OFF_ARB_CONFIG, 4'h0, 8'h00, 4);
            chk("arb readback", v[i][7:3], rd[7:3]);
        end
        $display("test arbitration done");
    endtask : t_arb

    task automatic t_block();
        logic [15:0] b;
        b = ASH_SCC_BASE_DEF + 16'h0003 * ASH_BLOCK_STRIDE;
        do_req(ASH_CMD_OPT_WR, ASH_OFF_BOARD_CTRL, 4'h0, 8'h01, 4);
        chk("board on", 1'b0, board_enabled_n);
        do_req(ASH_CMD_OPT_WR, 16'h0103, 4'h0, 8'h03, 4);
        sel(b + 16'h0002, 7, 1'b0);
        sel(b + 16'h0001, 4, 1'b0);
        sel(b + 16'h0004, 7, 1'b1);
        sel(ASH_SCC_BASE_DEF, 7, 1'b1);
        do_req(ASH_CMD_OPT_WR, 16'h0103, 4'h0, 8'h00, 4);
        sel(ASH_SCC_BASE_DEF, 7, 1'b0);
        $display("test select block done");
    endtask : t_block

    task automatic t_irq();
        do_req(ASH_CMD_SCC_WR, ASH_SCC_BASE_DEF, 4'h1, 8'h07, 7);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            chk("irq line", 1'b0, i_ash_bus_if.host_irq_line_three_n);
            cyc(1);
            chk("irq seen", 1'b1, irq_seen);
            do_req(ASH_CMD_SCC_RD, ASH_SCC_BASE_DEF, ASH_REG_IRQ_VECTOR, 8'h00, 7);
            chk("pending", 8'h01 << i, rd);
            do_req(ASH_CMD_SCC_WR, ASH_SCC_BASE_DEF, ASH_REG_CMD_ZERO, ASH_IRQ_RESET_CMD, 7);
            cyc(3);
            chk("irq cleared", 1'b1, i_ash_bus_if.host_irq_line_three_n);
        end
        dma_mode = 1'b1;
        pulse(0);
        chk("dma quiet", 1'b1, i_ash_bus_if.host_irq_line_three_n);
        do_req(ASH_CMD_SCC_WR, ASH_SCC_BASE_DEF, ASH_REG_CMD_ZERO, ASH_IRQ_RESET_CMD, 7);
        dma_mode = 1'b0;
        $display("test interrupt done");
    endtask : t_irq

    task automatic t_check();
        raise_bus_check_n = 1'b0;
        cyc(1);
        raise_bus_check_n = 1'b1;
        cyc(3);
        chk("check line", 1'b0, i_ash_bus_if.bus_check_line_n);
        chk("check seen", 1'b1, check_seen);
        do_req(ASH_CMD_OPT_RD, ASH_OFF_CHK_STATUS, 4'h0, 8'h00, 4);
        chk("check bit", 1'b0, rd[ASH_CHK_BIT]);
        $display("test channel check done");
    endtask : t_check

    task automatic t_disable();
        do_req(ASH_CMD_OPT_WR, ASH_OFF_BOARD_CTRL, 4'h0, 8'h00, 4);
        chk("board off", 1'b1, board_enabled_n);
        sel(ASH_SCC_BASE_DEF, 7, 1'b1);
        pulse(0);
        chk("irq masked", 1'b1, i_ash_bus_if.host_irq_line_three_n);
        $display("test disable done");
    endtask : t_disable

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req_cmd = ASH_CMD_OPT_RD;
        req_addr = 16'h0000;
        req_reg = 4'h0;
        req_wdata = 8'h00;
        raise_bus_check_n = 1'b1;
        evt = 3'h0;
        dma_mode = 1'b0;
        sel_hit = 1'b0;
        cyc(6);
        nrst = 1'b1;
        t_reset();
        t_arb();
        t_block();
        t_irq();
        t_check();
        t_disable();
        end_sim();
    end

    // the tests need well under a thousand cycles
    initial begin
        #(100 * 3000);
        error_cnt++;
        end_sim();
    end
endmodule : tb_adapter_serial_host_interface
